// file: hdl/svma_core.sv
// shared video memory access: dram/sram sharing, waits, char clock, video
// assumes processor bus, crt controller and strap bits are on sys_clk
//
// Behaviour
// - sram write enable only on selected writes
// - one wait state per sram access
// - sram address from processor when selected
// - character clock mark-space depends on mode
// - screen and processor latch enables complementary
// - too little slot time inserts wait
// - display enable registered from crt controller
// - two intensity levels chosen by attributes
// - wait generator gives one or five waits
// - address captured on address latch strobe
// - dram data driven under latch and output enable
// - sram word latched as screen address
// - row/column strobes, address split in halves
// - sram buffer enabled by select, direction control
// - refresh counter drives row address in refresh
// - bank select by bit 17, delayed edge
// - period counter loaded with eight or eleven
// - ten or sixteen pixels per character
// - refresh counter steps once per refresh slot
// - video word serialised at pixel rate
// - attributes registered before gating with pixels
// - pixel shift rate is 15 MHz
// - slow serial controller gets five waits
`default_nettype none
module svma_core
    import svma_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    // processor side
    input wire logic aleStrobe,
    input wire logic [17:0] localAd,
    input wire logic cpuWrite,
    input wire logic staticRamSelect,
    input wire logic bufDir,
    input wire logic dramReq,
    input wire logic dramOutputEnable,
    input wire logic ioCycleEnable,
    input wire logic ioSlowSel,
    input wire logic altGraphSel,
    output logic memoryWaitReady,
    output logic ioReady,
    output logic cpuDataOe,
    output logic [15:0] cpuReadData,
    output logic [17:0] latchedAddr,
    // static ram side
    input wire logic [10:0] crtcAddr,
    input wire logic [15:0] sramRdata,
    output logic [10:0] sramAddr,
    output logic sramWeN,
    output logic sramBufEn,
    output logic sramBufDir,
    // dynamic ram side
    input wire logic [15:0] dramRdata,
    output logic [1:0] dramRasN,
    output logic dramCasN,
    output logic dramWeN,
    output logic [7:0] dramAddr,
    // display side
    input wire logic crtcDisplayEn,
    input wire logic [1:0] attrIn,
    output logic charPeriodClock,
    output logic screenLatchEnable,
    output logic cpuLatchEnable,
    output logic displayWindowEnable,
    output logic pixelShiftTick,
    output logic videoPixel,
    output logic videoBright
);

    typedef struct packed {
        logic [2:0] acc;             // fractional pixel-rate stepper
        logic [4:0] bitCnt;          // pixel within character
        logic [3:0] markCnt;         // character period counter
        logic char_period_clock;                  // character clock, high = screen slot
        logic cclkDly;               // delayed copy for bank switching
        logic upperOk;               // upper bank may be selected
        logic dispEn;                // registered display enable
        logic [17:0] addr;           // latched processor address
        logic [15:0] scrAddr;        // screen address from sram
        logic scrPend;               // screen or refresh fetch owed
        logic [15:0] accAddr;        // address of running dram cycle
        logic [15:0] vidWord;        // fetched video word
        logic [15:0] rdData;         // fetched processor word
        logic [7:0] refCnt;          // refresh row
        svma_dram_state_type st;
        svma_owner_type owner;
        logic cpuDone;               // processor access served
        logic sramSelD;
        logic ioEnD;
        logic [IO_SR_W-1:0] waitSr;  // peripheral wait shifter
        logic [1:0] rasN;
        logic casN;
        logic weN;
        logic [7:0] dAddr;
    } svma_core_state_type;

    svma_core_state_type r_q;
    svma_core_state_type r_d;

    svma_vid_if vid ();

    // row half or column half of a 16-bit dram address
    function automatic logic [HALF_W-1:0] dramHalf(input logic [WORD_W-1:0] a, input logic row);
        dramHalf = row ? a[HALF_W-1:0] : a[WORD_W-1:HALF_W];
    endfunction

    // ones for n-1 extra wait cycles after the start cycle
    function automatic logic [IO_SR_W-1:0] waitFill(input int n);
        waitFill = IO_SR_W'((1 << (n - 1)) - 1);
    endfunction

    logic [3:0] accSum;          // stepper sum
    logic tick;                  // pixel period pulse
    logic charStart;             // last pixel of a character
    logic [4:0] lastBit;         // index of last pixel
    logic [4:0] ticksLeft;       // pixel ticks left in the character
    logic cpuGo;                 // processor dram cycle may start
    logic ioStart;               // first cycle of a peripheral access
    logic sramWait;              // first cycle of a static ram access
    logic dramWait;              // processor waits for dram

    // decode helpers shared by the state logic and outputs
    always_comb
    begin
        accSum = {1'b0, r_q.acc} + ACC_STEP;
        tick = accSum >= ACC_WRAP;
        lastBit = altGraphSel ? 5'(BITS_GRAPH - 5'h01) : 5'(BITS_ALPHA - 5'h01);
        charStart = tick && (r_q.bitCnt == lastBit);
        ticksLeft = 5'(lastBit - r_q.bitCnt);
        // room check, and no row opens before the bank mux has followed the slot edge
        cpuGo = dramReq && !r_q.cpuDone && !r_q.char_period_clock && !charStart && (r_q.cclkDly == r_q.char_period_clock)
            && (ticksLeft >= DRAM_MIN_TICKS);
        ioStart = ioCycleEnable && !r_q.ioEnD;
        sramWait = staticRamSelect && !r_q.sramSelD;
        dramWait = dramReq && !r_q.cpuDone;
    end

    // next state
    always_comb
    begin
        r_d = r_q;

        // pixel stepper: 3 pulses every 8 clocks give 15 MHz on average
        r_d.acc = tick ? 3'(accSum - ACC_WRAP) : accSum[2:0];
        if (tick)
        begin
            r_d.bitCnt = charStart ? 5'h00 : 5'(r_q.bitCnt + 5'h01);
        end

        // character clock: mark lasts from load to terminal count
        if (charStart)
        begin
            r_d.markCnt = altGraphSel ? LOAD_GRAPH : LOAD_ALPHA;
            r_d.char_period_clock = 1'b1;
        end
        else if (tick && r_q.markCnt != MARK_END)
        begin
            r_d.markCnt = 4'(r_q.markCnt + 4'h1);
            if (r_d.markCnt == MARK_END)
            begin
                r_d.char_period_clock = 1'b0;
            end
        end

        // bank multiplexer follows the delayed character clock edge
        r_d.cclkDly = r_q.char_period_clock;
        if (r_q.cclkDly != r_q.char_period_clock)
        begin
            // upper bank only in processor slots, screen stays low
            r_d.upperOk = !r_q.char_period_clock;
        end

        r_d.dispEn = crtcDisplayEn;

        // address latch holds for the rest of the cycle
        if (aleStrobe)
        begin
            r_d.addr = localAd;
        end

        // screen address taken from sram at character start, ras idle
        if (charStart && (r_q.rasN == RAS_NONE))
        begin
            r_d.scrAddr = sramRdata;
        end
        if (charStart)
        begin
            r_d.scrPend = 1'b1;
        end

        // released processor request rearms the next access
        if (!dramReq)
        begin
            r_d.cpuDone = 1'b0;
        end

        // dram cycle sequencer
        unique case (r_q.st)
            ST_IDLE:
            begin
                if (r_q.scrPend)
                begin
                    // screen fetch first; refresh outside display window
                    r_d.scrPend = 1'b0;
                    r_d.st = ST_ROW;
                    if (r_q.dispEn)
                    begin
                        r_d.owner = OWN_SCREEN;
                        r_d.accAddr = r_q.scrAddr;
                        r_d.rasN = RAS_LOWER;
                        r_d.dAddr = dramHalf(r_q.scrAddr, 1'b1);
                    end
                    else
                    begin
                        r_d.owner = OWN_REFRESH;
                        r_d.accAddr = {8'h00, r_q.refCnt};
                        r_d.rasN = RAS_BOTH;
                        r_d.dAddr = r_q.refCnt;
                    end
                end
                else if (cpuGo)
                begin
                    r_d.owner = OWN_CPU;
                    r_d.st = ST_ROW;
                    r_d.accAddr = r_q.addr[16:1];
                    r_d.rasN = (r_q.upperOk && r_q.addr[UPPER_BANK_BIT]) ? RAS_UPPER : RAS_LOWER;
                    r_d.dAddr = dramHalf(r_q.addr[16:1], 1'b1);
                end
            end
            ST_ROW:
            begin
                r_d.st = ST_COL;
                // refresh is ras-only; no column strobe
                r_d.casN = (r_q.owner == OWN_REFRESH);
                r_d.dAddr = dramHalf(r_q.accAddr, 1'b0);
                r_d.weN = !((r_q.owner == OWN_CPU) && cpuWrite);
            end
            ST_COL:
            begin
                r_d.st = ST_HOLD;
            end
            ST_HOLD:
            begin
                r_d.st = ST_IDLE;
                r_d.rasN = RAS_NONE;
                r_d.casN = 1'b1;
                r_d.weN = 1'b1;
                unique case (r_q.owner)
                    OWN_SCREEN:
                    begin
                        r_d.vidWord = dramRdata;
                    end
                    OWN_REFRESH:
                    begin
                        // one step per refresh slot, at ras release
                        r_d.refCnt = 8'(r_q.refCnt + 8'h01);
                    end
                    OWN_CPU:
                    begin
                        r_d.rdData = dramRdata;
                        r_d.cpuDone = dramReq;
                    end
                    default:
                    begin
                        r_d.owner = OWN_SCREEN;
                    end
                endcase
            end
            default:
            begin
                r_d.st = ST_IDLE;
                r_d.rasN = RAS_NONE;
                r_d.casN = 1'b1;
                r_d.weN = 1'b1;
            end
        endcase

        // static ram select edge for the single wait state
        r_d.sramSelD = staticRamSelect;

        // peripheral wait shifter: start cycle plus loaded ones
        r_d.ioEnD = ioCycleEnable;
        if (ioStart)
        begin
            r_d.waitSr = ioSlowSel ? waitFill(IO_WAIT_SLOW) : waitFill(IO_WAIT_FAST);
        end
        else
        begin
            r_d.waitSr = r_q.waitSr >> 1;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            r_q.owner <= OWN_SCREEN;
            r_q.rasN <= RAS_NONE;
            r_q.casN <= 1'b1;
            r_q.weN <= 1'b1;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // serialiser hookup; word loads as the screen latch opens
    assign vid.pixTick = tick;
    assign vid.loadWord = charStart;
    assign vid.word = r_q.vidWord;
    assign vid.attr = attrIn;
    assign vid.blank = !r_q.dispEn;

    svma_serialiser u_ser (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .vid(vid)
    );

    // processor handshakes; ready returns when the held access is done
    assign memoryWaitReady = !(sramWait || dramWait);
    assign ioReady = !(ioStart || r_q.waitSr[0]);

    // latch enables in antiphase
    assign screenLatchEnable = r_q.char_period_clock;
    assign cpuLatchEnable = !r_q.char_period_clock;
    assign cpuDataOe = cpuLatchEnable && dramOutputEnable;
    assign cpuReadData = r_q.rdData;
    assign latchedAddr = r_q.addr;

    // static ram path
    assign sramAddr = staticRamSelect ? r_q.addr[SRAM_AW:1] : crtcAddr;
    assign sramWeN = !(staticRamSelect && cpuWrite);
    assign sramBufEn = staticRamSelect;
    assign sramBufDir = bufDir;

    // dram pins
    assign dramRasN = r_q.rasN;
    assign dramCasN = r_q.casN;
    assign dramWeN = r_q.weN;
    assign dramAddr = r_q.dAddr;

    // display pins
    assign charPeriodClock = r_q.char_period_clock;
    assign displayWindowEnable = r_q.dispEn;
    assign pixelShiftTick = tick;
    assign videoPixel = vid.pixel;
    assign videoBright = vid.bright;

endmodule
`default_nettype wire

// file: inc/svma_pkg.sv
// shared constants and types of the shared video memory access block
// assumes a single 40 MHz system clock feeding every register
`default_nettype none
package svma_pkg;
    // clock rates in Hz; the pixel rate is made by a fractional stepper
    localparam int SYS_HZ = 40_000_000;
    localparam int PIXEL_HZ = 15_000_000;
    localparam int BASE_HZ = 5_000_000;
    localparam logic [3:0] ACC_STEP = 4'(PIXEL_HZ / BASE_HZ);
    localparam logic [3:0] ACC_WRAP = 4'(SYS_HZ / BASE_HZ);
    // character period counter loads and terminal count
    localparam logic [3:0] LOAD_ALPHA = 4'h8;
    localparam logic [3:0] LOAD_GRAPH = 4'hB;
    localparam logic [3:0] MARK_END = 4'hF;
    // pixels shown per character period
    localparam logic [4:0] BITS_ALPHA = 5'h0A;
    localparam logic [4:0] BITS_GRAPH = 5'h10;
    // least pixel ticks left in a processor slot to start a dram access
    localparam logic [4:0] DRAM_MIN_TICKS = 5'h02;
    // peripheral wait states
    localparam int IO_WAIT_FAST = 1;
    localparam int IO_WAIT_SLOW = 5;
    localparam int IO_SR_W = 4;
    // widths and field positions
    localparam int ADDR_W = 18;
    localparam int UPPER_BANK_BIT = 17;
    localparam int SRAM_AW = 11;
    localparam int WORD_W = 16;
    localparam int HALF_W = 8;
    localparam logic [1:0] RAS_LOWER = 2'h2;
    localparam logic [1:0] RAS_UPPER = 2'h1;
    localparam logic [1:0] RAS_BOTH = 2'h0;
    localparam logic [1:0] RAS_NONE = 2'h3;

    // dram cycle sequencer
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ROW = 4'h2,
        ST_COL = 4'h4,
        ST_HOLD = 4'h8
    } svma_dram_state_type;

    // who owns the running dram cycle
    typedef enum logic [2:0] {
        OWN_SCREEN = 3'h1,
        OWN_REFRESH = 3'h2,
        OWN_CPU = 3'h4
    } svma_owner_type;
endpackage
`default_nettype wire

// file: inc/svma_vid_if.sv
// carrier between the memory core and the pixel serialiser
// assumes both ends share sys_clk
`default_nettype none
interface svma_vid_if;
    logic pixTick;               // one pulse per pixel period
    logic loadWord;              // character start, as the screen latch opens
    logic [15:0] word;           // fetched video word
    logic [1:0] attr;            // [0] bright, [1] reverse
    logic blank;                 // outside display window
    logic pixel;
    logic bright;
    modport core (output pixTick, loadWord, word, attr, blank, input pixel, bright);
    modport ser (input pixTick, loadWord, word, attr, blank, output pixel, bright);
endinterface
`default_nettype wire

// file: hdl/svma_serialiser.sv
// pixel serialiser: 16-bit word to one pixel stream with attributes
// assumes pixTick and loadWord come from the core on the same clock
`default_nettype none
module svma_serialiser
    import svma_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    svma_vid_if.ser vid
);

    typedef struct packed {
        logic [15:0] shift;      // pixels, msb first
        logic [1:0] attr;        // attributes of the current character
        logic pix;
        logic bright;
    } svma_ser_state_type;

    svma_ser_state_type r_q;
    svma_ser_state_type r_d;

    // shift and attribute update
    always_comb
    begin
        r_d = r_q;
        if (vid.pixTick)
        begin
            // registered attributes gate the outgoing shift bit, never the raw vid.attr
            r_d.pix = (r_q.shift[15] ^ r_q.attr[1]) & ~vid.blank;
            r_d.bright = r_d.pix & r_q.attr[0];
            r_d.shift = {r_q.shift[14:0], 1'b0};
        end
        if (vid.loadWord)
        begin
            // load wins over the shift of the same tick
            r_d.shift = vid.word;
            r_d.attr = vid.attr;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign vid.pixel = r_q.pix;
    assign vid.bright = r_q.bright;

endmodule
`default_nettype wire

// file: bench/svma_mem_model.sv
// behavioural dram and static ram behind svma_core
// assumes strobes move only at sys_clk edges
`default_nettype none
module svma_mem_model
(
    input wire logic sys_clk,
    input wire logic [1:0] dramRasN,
    input wire logic dramCasN,
    input wire logic [7:0] dramAddr,
    input wire logic [10:0] sramAddr,
    output logic [15:0] dramRdata,
    output logic [15:0] sramRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rowByte_q = 8'h00; // row half of the word address
    logic [7:0] colByte_q = 8'h00; // column half
    logic [1:0] lastRas_q = 2'h3;
    logic lastCas_q = 1'b1;
    logic flip_q = 1'b0; // makes released data change every cycle
    // each half is taken in the first cycle its strobe is low
    always @(posedge sys_clk)
    begin
        if (dramRasN != 2'h3 && lastRas_q == 2'h3)
            rowByte_q <= dramAddr;
        if (!dramCasN && lastCas_q)
            colByte_q <= dramAddr;
        lastRas_q <= dramRasN;
        lastCas_q <= dramCasN;
        flip_q <= !flip_q;
    end
    // data only while a row is open, otherwise a toggling pattern
    assign dramRdata = {colByte_q, rowByte_q} ^ ((dramRasN != 2'h3) ? 16'h5A3C : {16{flip_q}});
    // pointers are 16-bit word addresses, so screen stays in the lower bank
    assign sramRdata = {sramAddr, 5'h00};
endmodule
`default_nettype wire

// file: bench/svma_core_sva.sv
// checker on svma_core ports: strobes, waits, muxes, pixel rate
// assumes one sys_clk domain and arst_n active low
`default_nettype none
module svma_core_sva
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic aleStrobe,
    input wire logic [17:0] localAd,
    input wire logic cpuWrite,
    input wire logic staticRamSelect,
    input wire logic dramReq,
    input wire logic ioCycleEnable,
    input wire logic ioSlowSel,
    input wire logic memoryWaitReady,
    input wire logic ioReady,
    input wire logic [17:0] latchedAddr,
    input wire logic [10:0] crtcAddr,
    input wire logic [10:0] sramAddr,
    input wire logic sramWeN,
    input wire logic [1:0] dramRasN,
    input wire logic dramCasN,
    input wire logic crtcDisplayEn,
    input wire logic charPeriodClock,
    input wire logic screenLatchEnable,
    input wire logic cpuLatchEnable,
    input wire logic displayWindowEnable,
    input wire logic pixelShiftTick,
    input wire logic videoPixel,
    input wire logic videoBright
);
    logic [7:0] tickHist_q; // last eight tick samples
    logic [3:0] fill_q; // samples taken, stops at eight
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // history restarts with reset so no stale ticks sit in the window
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tickHist_q <= 8'h00;
            fill_q <= 4'h0;
        end
        else
        begin
            tickHist_q <= {tickHist_q[6:0], pixelShiftTick};
            fill_q <= fill_q + {3'h0, fill_q != 4'h8};
        end
    end
    a_sram_we_gate: assert property (sramWeN == !(staticRamSelect && cpuWrite))
        else $error("sram write enable wrong");
    a_sram_one_wait: assert property ($rose(staticRamSelect) && !dramReq |->
        !memoryWaitReady ##1 (memoryWaitReady || !staticRamSelect || dramReq))
        else $error("sram wait not one cycle");
    a_sram_addr_mux: assert property (sramAddr == (staticRamSelect ? latchedAddr[11:1] : crtcAddr))
        else $error("sram address source wrong");
    a_latch_anti: assert property (screenLatchEnable == charPeriodClock && cpuLatchEnable != charPeriodClock)
        else $error("latch enables not complementary");
    a_disp_delay: assert property ($rose(crtcDisplayEn) |=> $rose(displayWindowEnable))
        else $error("display window enable not one clock late");
    a_ale_capture: assert property (aleStrobe |=> latchedAddr == $past(localAd))
        else $error("address not captured");
    a_io_fast: assert property ($rose(ioCycleEnable) && !ioSlowSel |-> !ioReady ##1 ioReady)
        else $error("fast io wait wrong");
    a_io_slow: assert property ($rose(ioCycleEnable) && ioSlowSel |-> !ioReady [*5] ##1 ioReady)
        else $error("slow io wait wrong");
    a_cas_in_row: assert property (!dramCasN |-> dramRasN != 2'h3)
        else $error("column strobe without row strobe");
    a_refresh_no_cas: assert property (dramRasN == 2'h0 |-> dramCasN)
        else $error("column strobe in refresh");
    a_bright_pixel: assert property (videoBright |-> videoPixel)
        else $error("bright without pixel");
    a_pixel_rate: assert property (fill_q == 4'h8 |-> $countones(tickHist_q) == 3)
        else $error("pixel tick rate wrong");
    c_sram_access: cover property ($rose(staticRamSelect));
    c_upper_bank: cover property (dramRasN == 2'h1);
    c_refresh: cover property (dramRasN == 2'h0);
    c_slow_io: cover property ($rose(ioCycleEnable) && ioSlowSel);
endmodule
bind svma_core svma_core_sva u_sva (.*);
`default_nettype wire

// file: bench/tb.sv
// bench for svma_core: static ram, io waits, char clock, dram, video
// assumes svma_mem_model stands in for the memory parts
`default_nettype none
module tb
    import svma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    int num_checks = 0;
    int n_mismatch = 0;
    int tk, mk, bad, n, ones;
    int nRef = 0; // refresh cycles seen
    logic sys_clk = 1'b0, arst_n = 1'b0, aleStrobe = 1'b0, cpuWrite = 1'b0, staticRamSelect = 1'b0;
    logic bufDir = 1'b0, dramReq = 1'b0, dramOutputEnable = 1'b0, ioCycleEnable = 1'b0, ioSlowSel = 1'b0;
    logic altGraphSel = 1'b0, crtcDisplayEn = 1'b0;
    logic [17:0] localAd = 18'h00000, latchedAddr;
    logic [10:0] crtcAddr = 11'h000, sramAddr;
    logic [1:0] attrIn = 2'h0, dramRasN, startRas;
    logic [1:0] lastRas = 2'h3;
    logic memoryWaitReady, ioReady, cpuDataOe, sramWeN, sramBufEn, sramBufDir, dramCasN, dramWeN, startClk, casWe;
    logic charPeriodClock, screenLatchEnable, cpuLatchEnable, displayWindowEnable, pixelShiftTick;
    logic videoPixel, videoBright;
    logic [15:0] cpuReadData, dramRdata, sramRdata;
    logic [7:0] dramAddr, refPrev, refLast;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
$display("unexpected at %0t: got %0h exp %0h", $time, (a), (b)); end end
    svma_core u_dut (.*);
    svma_mem_model u_mem (.*);
    // free-running system clock
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // note where each dram cycle starts, and refresh row addresses
    always @(posedge sys_clk)
    begin
        if (dramRasN !== 2'h3 && lastRas === 2'h3)
        begin
            startRas = dramRasN;
            startClk = charPeriodClock;
            if (dramRasN === 2'h0)
            begin
                refPrev = refLast;
                refLast = dramAddr;
                nRef++;
            end
        end
        lastRas = dramRasN;
        // write strobe level seen with the column strobe
        if (dramCasN === 1'b0)
            casWe = dramWeN;
    end
    // ticks and mark ticks up to the next rise of the char clock
    task automatic measure();
        logic lc;
        lc = 1'b1;
        tk = 0;
        mk = 0;
        #2;
        for (int i = 0; i < 300 && !(charPeriodClock === 1'b1 && lc === 1'b0); i++)
        begin
            lc = charPeriodClock;
            tk += int'(pixelShiftTick);
            mk += int'(pixelShiftTick & charPeriodClock);
            @(posedge sys_clk);
            #2;
        end
    endtask
    // bounded wait for a char clock level
    task automatic waitClk(input logic v);
        @(posedge sys_clk) #2;
        for (int i = 0; i < 200 && charPeriodClock !== v; i++)
            @(posedge sys_clk) #2;
        `CHK({charPeriodClock, cpuDataOe}, {v, !v & dramOutputEnable})
    endtask
    // single exit with the verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        crtcAddr <= 11'h123;
        // static ram write then read: one wait, address mux, buffer
        for (int w = 1; w >= 0; w--)
        begin
            @(posedge sys_clk) aleStrobe <= 1'b1;
            localAd <= 18'h02ABC;
            @(posedge sys_clk) aleStrobe <= 1'b0;
            staticRamSelect <= 1'b1;
            cpuWrite <= w[0];
            bufDir <= w[0];
            #2;
            `CHK(latchedAddr, 18'h02ABC)
            `CHK({memoryWaitReady, sramAddr}, {1'b0, 11'h55E})
            `CHK({sramWeN, sramBufEn, sramBufDir}, {!w[0], 1'b1, w[0]})
            @(posedge sys_clk) #2;
            `CHK(memoryWaitReady, 1'b1)
            @(posedge sys_clk) staticRamSelect <= 1'b0;
            #2;
            `CHK({sramWeN, sramAddr}, {1'b1, 11'h123})
        end
        // fast then slow peripheral waits
        for (int s = 0; s < 2; s++)
        begin
            @(posedge sys_clk) ioSlowSel <= s[0];
            ioCycleEnable <= 1'b1;
            #2;
            for (n = 0; n < 20 && ioReady !== 1'b1; n++)
                @(posedge sys_clk) #2;
            `CHK(n, s ? IO_WAIT_SLOW : IO_WAIT_FAST)
            @(posedge sys_clk) ioCycleEnable <= 1'b0;
        end
        // character period and mark in both modes
        for (int g = 0; g < 2; g++)
        begin
            @(posedge sys_clk) altGraphSel <= g[0];
            repeat (3) measure();
            `CHK(tk, g ? int'(BITS_GRAPH) : int'(BITS_ALPHA))
            `CHK(mk, int'(MARK_END - (g ? LOAD_GRAPH : LOAD_ALPHA)))
        end
        // processor dram read then write, lower then upper bank
        @(posedge sys_clk) dramOutputEnable <= 1'b1;
        // lower read in a processor slot, then upper write held off from a screen slot
        for (int b = 0; b < 2; b++)
        begin
            waitClk(!b[0]);
            waitClk(b[0]);
            @(posedge sys_clk) aleStrobe <= 1'b1;
            localAd <= {b[0], 17'h0A5C6};
            @(posedge sys_clk) aleStrobe <= 1'b0;
            dramReq <= 1'b1;
            cpuWrite <= b[0];
            #2;
            `CHK(memoryWaitReady, 1'b0)
            for (n = 0; n < 200 && memoryWaitReady !== 1'b1; n++)
                @(posedge sys_clk) #2;
            `CHK({memoryWaitReady, cpuReadData}, {1'b1, 16'h08DF})
            `CHK({startRas, startClk}, {b ? 2'h1 : 2'h2, 1'b0})
            `CHK(casWe, !b[0])
            @(posedge sys_clk) dramReq <= 1'b0;
            cpuWrite <= 1'b0;
        end
        // at least two refresh rows seen, and the last two step by one
        `CHK(nRef > 1, 1'b1)
        `CHK(refLast, refPrev + 8'h01)
        // window enable one clock late
        @(posedge sys_clk) crtcDisplayEn <= 1'b1;
        #2;
        `CHK(displayWindowEnable, 1'b0)
        @(posedge sys_clk) #2;
        `CHK(displayWindowEnable, 1'b1)
        // plain, bright, then reverse with the window shut
        for (int a = 0; a < 3; a++)
        begin
            @(posedge sys_clk) attrIn <= (a == 2) ? 2'h3 : a[1:0];
            crtcDisplayEn <= (a != 2);
            repeat (2) measure();
            bad = 0;
            ones = 0;
            repeat (60)
            begin
                @(posedge sys_clk) #2;
                bad += int'(videoBright !== (videoPixel & attrIn[0]) || (a == 2 && videoPixel !== 1'b0));
                ones += int'(videoPixel === 1'b1);
            end
            `CHK(bad, 0)
            `CHK(ones > 0, a != 2)
        end
        close_out();
    end
endmodule
`default_nettype wire
